/* rtl/fop_port_decode.sv */
`timescale 1ns/10ps
module fop_port_decode (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_primary_reset_n,
    input wire logic i_flag_select0_serial_data,
    input wire logic i_flag_select1_serial_enable,
    input wire logic i_flag_select2,
    input wire logic i_port_a_select_n,
    input wire logic i_port_a_write_read,
    input wire logic i_port_a_enable,
    input wire logic i_port_a_mailbox_select,
    input wire logic [fop_pkg::DATA_W-1:0] i_port_a_data,
    output logic [fop_pkg::DATA_W-1:0] o_port_a_data,
    output logic o_port_a_data_oe,
    input wire logic i_port_b_select_n,
    input wire logic i_port_b_write_read,
    input wire logic i_port_b_enable,
    input wire logic i_port_b_mailbox_select,
    input wire logic [fop_pkg::DATA_W-1:0] i_port_b_data,
    output logic [fop_pkg::DATA_W-1:0] o_port_b_data,
    output logic o_port_b_data_oe,
    output logic o_full_input_ready_flag,
    output logic o_empty_output_ready_flag,
    output logic o_mailbox_one_flag,
    output logic o_mailbox_two_flag,
    output logic [fop_pkg::OFS_W-1:0] o_almost_empty_offset,
    output logic [fop_pkg::OFS_W-1:0] o_almost_full_offset,
    output logic o_interleaved_parity_mode
);

    typedef struct packed {
        fop_pkg::fop_mode_e mode;
        logic rst_prev;
        logic [2:0] sel;
        logic ip;
        logic [fop_pkg::OFS_W-1:0] x;
        logic [fop_pkg::OFS_W-1:0] y;
        logic [fop_pkg::SERIAL_BITS-1:0] sr;
        logic [fop_pkg::CNT_W-1:0] cnt;
        logic [fop_pkg::DATA_W-1:0] mailbox_one;
        logic [fop_pkg::DATA_W-1:0] mailbox_two;
        logic mailbox_one_flag;
        logic mailbox_two_flag;
        logic [fop_pkg::DATA_W-1:0] a_out;
        logic [fop_pkg::DATA_W-1:0] b_out;
    } fop_state_s;

    fop_state_s s;
    fop_state_s next_s;

    logic fifo_ready;
    logic fifo_valid;
    logic [fop_pkg::DATA_W-1:0] fifo_data;
    logic active;
    logic programming;
    logic a_write_qual;
    logic fifo_push;
    logic fifo_pop;
    logic a_mailbox;
    logic b_mailbox;
    logic [fop_pkg::SERIAL_BITS-1:0] sr_shifted;

    // Offset bits from Port A; the top bit used is the offset MSB.
    function automatic logic [fop_pkg::OFS_W-1:0] port_offset(
        input logic [fop_pkg::DATA_W-1:0] d,
        input logic ip
    );
        if (ip) begin
            port_offset = {d[fop_pkg::OFS_W:fop_pkg::IP_HIGH_LSB],
                           d[fop_pkg::IP_SKIP_BIT-1:0]};
        end else begin
            port_offset = d[fop_pkg::OFS_W-1:0];
        end
    endfunction

    function automatic logic [fop_pkg::OFS_W-1:0] preset_offset(input logic [2:0] sel);
        unique case (sel)
            fop_pkg::SEL_PRESET_64: preset_offset = fop_pkg::OFS_64;
            fop_pkg::SEL_PRESET_16: preset_offset = fop_pkg::OFS_16;
            fop_pkg::SEL_PRESET_8: preset_offset = fop_pkg::OFS_8;
            fop_pkg::SEL_PRESET_256: preset_offset = fop_pkg::OFS_256;
            fop_pkg::SEL_PRESET_1024: preset_offset = fop_pkg::OFS_1024;
            default: preset_offset = fop_pkg::OFS_RESET;
        endcase
    endfunction

    assign active = i_primary_reset_n && s.rst_prev && (s.mode != fop_pkg::FOP_HOLD)
        && (s.mode != fop_pkg::FOP_SERIAL);
    assign programming = (s.mode == fop_pkg::FOP_PAR_Y) || (s.mode == fop_pkg::FOP_PAR_X);

    // Input ready stays low in hold and during serial loading; the FIFO has room in parallel states.
    assign o_full_input_ready_flag = active && fifo_ready;
    assign o_empty_output_ready_flag = active && fifo_valid;

    // Offset-loading writes share the ordinary FIFO write qualifiers.
    assign a_write_qual = !i_port_a_select_n && i_port_a_write_read && i_port_a_enable
        && !i_port_a_mailbox_select && o_full_input_ready_flag;
    assign fifo_push = a_write_qual && (s.mode == fop_pkg::FOP_RUN);
    assign fifo_pop = !i_port_b_select_n && i_port_b_write_read && i_port_b_enable
        && !i_port_b_mailbox_select && o_empty_output_ready_flag;
    assign a_mailbox = active && !i_port_a_select_n && i_port_a_enable
        && i_port_a_mailbox_select;
    assign b_mailbox = active && !i_port_b_select_n && i_port_b_enable
        && i_port_b_mailbox_select;

    assign o_port_a_data_oe = !i_port_a_select_n && !i_port_a_write_read;
    assign o_port_b_data_oe = !i_port_b_select_n && i_port_b_write_read;
    assign o_port_a_data = s.a_out;
    assign o_port_b_data = s.b_out;
    assign o_mailbox_one_flag = s.mailbox_one_flag;
    assign o_mailbox_two_flag = s.mailbox_two_flag;
    assign o_almost_empty_offset = s.x;
    assign o_almost_full_offset = s.y;
    assign o_interleaved_parity_mode = s.ip;

    assign sr_shifted = {s.sr[fop_pkg::SERIAL_BITS-2:0], i_flag_select0_serial_data};

    always_comb begin
        next_s = s;
        next_s.rst_prev = i_primary_reset_n;
        if (!i_primary_reset_n) begin
            next_s.mode = fop_pkg::FOP_HOLD;
            next_s.mailbox_one_flag = 1'b1;
            next_s.mailbox_two_flag = 1'b1;
        end else if (!s.rst_prev) begin
            // Rising edge of the primary reset: the method is fixed from here on.
            next_s.sel = {i_flag_select2, i_flag_select1_serial_enable,
                          i_flag_select0_serial_data};
            next_s.ip = (next_s.sel == fop_pkg::SEL_INTERLEAVED);
            next_s.cnt = '0;
            unique case (next_s.sel)
                fop_pkg::SEL_SERIAL: next_s.mode = fop_pkg::FOP_SERIAL;
                fop_pkg::SEL_PARALLEL,
                fop_pkg::SEL_INTERLEAVED: next_s.mode = fop_pkg::FOP_PAR_Y;
                default: begin
                    next_s.x = preset_offset(next_s.sel);
                    next_s.y = preset_offset(next_s.sel);
                    next_s.mode = fop_pkg::FOP_RUN;
                end
            endcase
        end else begin
            unique case (s.mode)
                fop_pkg::FOP_SERIAL: begin
                    if (s.cnt > fop_pkg::SERIAL_LAST) begin
                        next_s.mode = fop_pkg::FOP_RUN;
                    end else if (!i_flag_select1_serial_enable) begin
                        next_s.sr = sr_shifted;
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == fop_pkg::SERIAL_LAST) begin
                            // First bits shifted form Y, the later ones X; ready follows next edge.
                            next_s.y = sr_shifted[fop_pkg::SERIAL_BITS-1:fop_pkg::OFS_W];
                            next_s.x = sr_shifted[fop_pkg::OFS_W-1:0];
                        end
                    end
                end
                fop_pkg::FOP_PAR_Y: begin
                    if (a_write_qual) begin
                        next_s.y = port_offset(i_port_a_data, s.ip);
                        next_s.mode = fop_pkg::FOP_PAR_X;
                    end
                end
                fop_pkg::FOP_PAR_X: begin
                    if (a_write_qual) begin
                        next_s.x = port_offset(i_port_a_data, s.ip);
                        next_s.mode = fop_pkg::FOP_RUN;
                    end
                end
                fop_pkg::FOP_RUN,
                fop_pkg::FOP_HOLD: begin
                end
                default: begin
                    next_s.mode = fop_pkg::FOP_HOLD;
                end
            endcase
            // Writes clear a mailbox flag first so that a read in the same cycle wins.
            if (a_mailbox && i_port_a_write_read) begin
                next_s.mailbox_one = i_port_a_data;
                next_s.mailbox_one_flag = 1'b0;
            end
            if (b_mailbox && !i_port_b_write_read) begin
                next_s.mailbox_two = i_port_b_data;
                next_s.mailbox_two_flag = 1'b0;
            end
            if (a_mailbox && !i_port_a_write_read) begin
                next_s.a_out = s.mailbox_two;
                next_s.mailbox_two_flag = 1'b1;
            end
            if (b_mailbox && i_port_b_write_read) begin
                next_s.b_out = s.mailbox_one;
                next_s.mailbox_one_flag = 1'b1;
            end
            if (fifo_pop) begin
                next_s.b_out = fifo_data;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // The small buffer stands in for the storage array; a full buffer stalls Port A until Port B reads a word from it.
    fop_fifo #(
        .WIDTH(fop_pkg::DATA_W),
        .DEPTH(fop_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(!i_primary_reset_n),
        .i_valid(fifo_push),
        .o_ready(fifo_ready),
        .i_data(i_port_a_data),
        .o_valid(fifo_valid),
        .i_ready(fifo_pop),
        .o_data(fifo_data)
    );

    property p_capture;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_primary_reset_n && !s.rst_prev) |=> (s.sel == $past({i_flag_select2,
            i_flag_select1_serial_enable, i_flag_select0_serial_data}));
    endproperty
    a_capture: assert property (p_capture) else $error("selects not captured");

    property p_preset64;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_primary_reset_n && !s.rst_prev && i_flag_select2 && i_flag_select1_serial_enable
            && i_flag_select0_serial_data) |=> (s.x == fop_pkg::OFS_64)
            && (s.y == fop_pkg::OFS_64) && (s.mode == fop_pkg::FOP_RUN);
    endproperty
    a_preset64: assert property (p_preset64) else $error("preset 64 not loaded");

    property p_serial_last;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_primary_reset_n && s.rst_prev && s.mode == fop_pkg::FOP_SERIAL
            && !i_flag_select1_serial_enable && s.cnt == fop_pkg::SERIAL_LAST)
            |=> !o_full_input_ready_flag && (s.x[0] == $past(i_flag_select0_serial_data))
            ##1 (o_full_input_ready_flag || !i_primary_reset_n || !s.rst_prev);
    endproperty
    a_serial_last: assert property (p_serial_last) else $error("serial end wrong");

    property p_serial_ff_low;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (s.mode == fop_pkg::FOP_SERIAL) |-> !o_full_input_ready_flag;
    endproperty
    a_serial_ff_low: assert property (p_serial_ff_low) else $error("ready during serial");

    property p_par_y;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_primary_reset_n && s.mode == fop_pkg::FOP_PAR_Y && a_write_qual)
            |-> !fifo_push ##1 (s.mode == fop_pkg::FOP_PAR_X);
    endproperty
    a_par_y: assert property (p_par_y) else $error("Y load not taken");

    property p_ip_no_serial;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        s.ip |-> (s.mode != fop_pkg::FOP_SERIAL);
    endproperty
    a_ip_no_serial: assert property (p_ip_no_serial) else $error("serial in parity mode");

    property p_enable_low;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        !i_port_a_enable |-> !fifo_push && !a_mailbox;
    endproperty
    a_enable_low: assert property (p_enable_low) else $error("op with enable low");

    property p_push_qual;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        fifo_push |-> o_full_input_ready_flag && !i_port_a_select_n && i_port_a_write_read;
    endproperty
    a_push_qual: assert property (p_push_qual) else $error("bad FIFO write");

    property p_pop_data;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        fifo_pop |=> (o_port_b_data == $past(fifo_data));
    endproperty
    a_pop_data: assert property (p_pop_data) else $error("FIFO read data wrong");

    property p_b_oe;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (fifo_pop || (b_mailbox && i_port_b_write_read)) |-> o_port_b_data_oe;
    endproperty
    a_b_oe: assert property (p_b_oe) else $error("Port B read while not driving");

    property p_mailbox_two_flag_read;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (a_mailbox && !i_port_a_write_read && i_primary_reset_n) |=> o_mailbox_two_flag
            && (o_port_a_data == $past(s.mailbox_two));
    endproperty
    a_mailbox_two_flag_read: assert property (p_mailbox_two_flag_read) else $error("mailbox two read wrong");

    property p_mailbox_one_flag_read;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (b_mailbox && i_port_b_write_read && i_primary_reset_n) |=> o_mailbox_one_flag;
    endproperty
    a_mailbox_one_flag_read: assert property (p_mailbox_one_flag_read) else $error("mailbox one flag not set");

endmodule // fop_port_decode

/* pkg/fop_pkg.sv */
package fop_pkg;

    localparam int DATA_W = 36;
    localparam int OFS_W = 13;
    localparam int SERIAL_BITS = 2 * OFS_W;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] SERIAL_LAST = 5'h19;
    localparam int FIFO_DEPTH = 4;

    localparam int IP_SKIP_BIT = 8;
    localparam int IP_HIGH_LSB = 9;

    localparam logic [2:0] SEL_PRESET_64 = 3'h7;
    localparam logic [2:0] SEL_PRESET_16 = 3'h6;
    localparam logic [2:0] SEL_PRESET_8 = 3'h5;
    localparam logic [2:0] SEL_PRESET_256 = 3'h3;
    localparam logic [2:0] SEL_PRESET_1024 = 3'h1;
    localparam logic [2:0] SEL_SERIAL = 3'h2;
    localparam logic [2:0] SEL_PARALLEL = 3'h4;
    localparam logic [2:0] SEL_INTERLEAVED = 3'h0;

    localparam logic [OFS_W-1:0] OFS_64 = 13'h0040;
    localparam logic [OFS_W-1:0] OFS_16 = 13'h0010;
    localparam logic [OFS_W-1:0] OFS_8 = 13'h0008;
    localparam logic [OFS_W-1:0] OFS_256 = 13'h0100;
    localparam logic [OFS_W-1:0] OFS_1024 = 13'h0400;
    localparam logic [OFS_W-1:0] OFS_RESET = 13'h0000;

    typedef enum logic [2:0] {
        FOP_HOLD = 3'b000,
        FOP_SERIAL = 3'b001,
        FOP_PAR_Y = 3'b010,
        FOP_PAR_X = 3'b011,
        FOP_RUN = 3'b100
    } fop_mode_e;

endpackage

/* rtl/fop_fifo.sv */
`timescale 1ns/10ps
module fop_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clear,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
    } fop_fifo_s;

    fop_fifo_s s;
    fop_fifo_s next_s;
    logic push;
    logic pop;

    assign o_ready = (s.count != (PTR_W + 1)'(DEPTH));
    assign o_valid = (s.count != '0);
    assign o_data = s.mem[s.rd_ptr];
    assign push = i_valid && o_ready;
    assign pop = i_ready && o_valid;

    always_comb begin
        next_s = s;
        if (i_clear) begin
            next_s.wr_ptr = '0;
            next_s.rd_ptr = '0;
            next_s.count = '0;
        end else begin
            if (push) begin
                next_s.mem[s.wr_ptr] = i_data;
                next_s.wr_ptr = s.wr_ptr + 1'b1;
            end
            if (pop) begin
                next_s.rd_ptr = s.rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                next_s.count = s.count + 1'b1;
            end else if (pop && !push) begin
                next_s.count = s.count - 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule // fop_fifo

/* bench/fop_port_master.sv */
`timescale 1ns/10ps
// Stands in for the Port B bus master; its controls follow i_mode at once, so the
// bench decides on which edges a request is presented and when it is dropped.
module fop_port_master (
    input wire logic i_sys_clk,
    input wire logic [1:0] i_mode,
    input wire logic [35:0] i_data,
    output logic o_select_n,
    output logic o_write_read,
    output logic o_enable,
    output logic o_mailbox_select,
    output logic [35:0] o_data
);
    logic [35:0] pat = 36'h5_5555_5555;

    // A released bus must not keep showing the last word, so it toggles every cycle.
    always @(posedge i_sys_clk) begin
        pat <= ~pat;
    end

    always_comb begin
        o_select_n = (i_mode == 2'h0);
        o_write_read = (i_mode != 2'h3);
        o_enable = (i_mode != 2'h0);
        o_mailbox_select = i_mode[1];
        o_data = (i_mode == 2'h3) ? i_data : pat;
    end
endmodule // fop_port_master

/* bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic clk, rst, prn, fs0, fs1, fs2, a_sel_n, a_wr, a_en, a_mb;
    logic a_oe, b_oe, b_sel_n, b_wr, b_en, b_mb, full, empty, mf1, mf2, ipm;
    logic [35:0] a_d, a_q, b_d, b_q, m_d, d, d1, d2;
    logic [1:0] mode;
    logic [12:0] x_ofs, y_ofs;
    logic [31:0] seed;
    logic [35:0] exp_q [$];
    logic [2:0] psel [5] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h1};
    logic [12:0] pval [5] = '{13'h0040, 13'h0010, 13'h0008, 13'h0100, 13'h0400};
    int n_fail, num_checks, k;
    logic take;

    fop_port_decode fop_port_decode_i (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_primary_reset_n(prn),
        .i_flag_select0_serial_data(fs0), .i_flag_select1_serial_enable(fs1),
        .i_flag_select2(fs2), .i_port_a_select_n(a_sel_n), .i_port_a_write_read(a_wr),
        .i_port_a_enable(a_en), .i_port_a_mailbox_select(a_mb), .i_port_a_data(a_d),
        .o_port_a_data(a_q), .o_port_a_data_oe(a_oe), .i_port_b_select_n(b_sel_n),
        .i_port_b_write_read(b_wr), .i_port_b_enable(b_en), .i_port_b_mailbox_select(b_mb),
        .i_port_b_data(b_d), .o_port_b_data(b_q), .o_port_b_data_oe(b_oe),
        .o_full_input_ready_flag(full), .o_empty_output_ready_flag(empty),
        .o_mailbox_one_flag(mf1), .o_mailbox_two_flag(mf2), .o_almost_empty_offset(x_ofs),
        .o_almost_full_offset(y_ofs), .o_interleaved_parity_mode(ipm)
    );

    fop_port_master fop_port_master_i (
        .i_sys_clk(clk), .i_mode(mode), .i_data(m_d), .o_select_n(b_sel_n),
        .o_write_read(b_wr), .o_enable(b_en), .o_mailbox_select(b_mb), .o_data(b_d)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic rnd(output logic [35:0] v);
        seed = lfsr(seed);
        v = {seed[31:28], seed};
    endtask

    // Offsets stay inside the legal range: top bit cleared, bottom bit set.
    task automatic rnd_ofs(output logic [35:0] v, input int top, input int bottom);
        rnd(v);
        v[top] = 1'b0;
        v[bottom] = 1'b1;
    endtask

    task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic tick;
        @(posedge clk);
        #5;
    endtask

    task automatic a_drive(input logic s, w, e, m, input logic [35:0] v);
        a_sel_n = s;
        a_wr = w;
        a_en = e;
        a_mb = m;
        a_d = v;
    endtask

    // The request stays up after the taking edge so that writes can run back to back.
    // Ready is looked at after it has settled, before the edge that takes the word.
    task automatic a_write(input logic [35:0] v);
        int i;
        a_drive(1'b0, 1'b1, 1'b1, 1'b0, v);
        for (i = 0; i < 40 && full !== 1'b1; i++) tick;
        if (i == 40) begin
            chk("write_ready", full, 1'b1);
            results();
        end
        tick;
    endtask

    task automatic setup(input logic [2:0] s);
        a_drive(1'b1, 1'b0, 1'b0, 1'b0, 36'h0_0000_0000);
        mode = 2'h0;
        prn = 1'b0;
        {fs2, fs1, fs0} = s;
        tick;
        tick;
        prn = 1'b1;
        tick;
    endtask

    initial begin
        forever begin
            @(negedge clk);
            take = b_sel_n === 1'b0 && b_wr === 1'b1 && b_en === 1'b1 && b_mb === 1'b0
                && empty === 1'b1;
            @(posedge clk);
            #1;
            if (take) begin
                if (exp_q.size() == 0) begin
                    n_fail++;
                    $display("[ERR] read_word expected none seen %h", b_q);
                end else begin
                    chk("read_word", b_q, exp_q.pop_front());
                end
            end
        end
    end

    initial begin
        rst = 1'b1;
        prn = 1'b0;
        {fs2, fs1, fs0} = 3'h0;
        mode = 2'h0;
        m_d = 36'h0_0000_0000;
        seed = 32'h0000_211d;
        n_fail = 0;
        num_checks = 0;
        a_drive(1'b1, 1'b0, 1'b0, 1'b0, 36'h0_0000_0000);
        repeat (16) @(posedge clk);
        #5;
        rst = 1'b0;
        for (k = 0; k < 5; k++) begin
            setup(psel[k]);
            chk("x_preset", x_ofs, pval[k]);
            chk("y_preset", y_ofs, pval[k]);
            chk("full_preset", full, 1'b1);
        end
        setup(3'h4); // Selects 0 and 1 stay low until the serial test
        chk("full_par", full, 1'b1);
        rnd(d);
        a_drive(1'b0, 1'b1, 1'b0, 1'b0, d);
        tick;
        rnd_ofs(d1, 12, 0);
        a_write(d1);
        chk("y_par", y_ofs, d1[12:0]);
        rnd_ofs(d2, 12, 0);
        a_write(d2);
        chk("x_par", x_ofs, d2[12:0]);
        chk("y_par_kept", y_ofs, d1[12:0]);
        chk("empty_par", empty, 1'b0);
        chk("ip_par", ipm, 1'b0);
        for (k = 0; k < 4; k++) begin
            rnd(d);
            a_write(d);
            exp_q.push_back(d);
        end
        chk("full_at_4", full, 1'b0);
        chk("empty_at_4", empty, 1'b1);
        rnd(d);
        a_d = d;
        tick;
        tick;
        mode = 2'h1;
        // Writes go on while the far side drains, so both ports are busy together.
        for (k = 0; k < 6; k++) begin
            rnd(d);
            a_write(d);
            exp_q.push_back(d);
        end
        a_sel_n = 1'b1;
        for (k = 0; k < 40 && exp_q.size() > 0; k++) tick;
        chk("drained", exp_q.size(), 36'h0_0000_0000);
        tick;
        chk("empty_end", empty, 1'b0);
        setup(3'h0);
        rnd_ofs(d1, 13, 0);
        a_write(d1);
        rnd_ofs(d2, 13, 0);
        a_write(d2);
        a_sel_n = 1'b1;
        chk("y_ip", y_ofs, {d1[13:9], d1[7:0]});
        chk("x_ip", x_ofs, {d2[13:9], d2[7:0]});
        chk("interleaved_parity_mode", ipm, 1'b1);
        rnd(d);
        tick;
        a_drive(1'b0, 1'b1, 1'b0, 1'b1, d);
        #1 chk("a_oe_write", a_oe, 1'b0);
        tick;
        chk("mf1_enable_low", mf1, 1'b1);
        a_en = 1'b1;
        tick;
        a_sel_n = 1'b1;
        chk("mf1_written", mf1, 1'b0);
        mode = 2'h2;
        #1 chk("b_oe_read", b_oe, 1'b1);
        tick;
        mode = 2'h0;
        chk("mail_one", b_q, d);
        chk("mf1_read", mf1, 1'b1);
        rnd(m_d);
        tick;
        mode = 2'h3;
        #1 chk("b_oe_write", b_oe, 1'b0);
        tick;
        mode = 2'h0;
        chk("mf2_written", mf2, 1'b0);
        a_drive(1'b0, 1'b0, 1'b1, 1'b1, 36'h0_0000_0000);
        #1 chk("a_oe_read", a_oe, 1'b1);
        tick;
        a_sel_n = 1'b1;
        chk("mail_two", a_q, m_d);
        chk("mf2_read", mf2, 1'b1);
        tick;
        setup(3'h2);
        chk("full_serial", full, 1'b0);
        rnd_ofs(d, 25, 13);
        d[12] = 1'b0;
        d[0] = 1'b1;
        for (k = 25; k >= 0; k--) begin
            if (k == 12) begin
                fs1 = 1'b1;
                fs0 = ~d[k];
                tick;
            end
            fs1 = 1'b0;
            fs0 = d[k];
            tick;
            chk("full_shifting", full, 1'b0);
        end
        fs1 = 1'b1;
        tick;
        chk("full_after", full, 1'b1);
        chk("y_serial", y_ofs, d[25:13]);
        chk("x_serial", x_ofs, d[12:0]);
        results();
    end
endmodule // tb_top
